// File: spc_pkg.sv
/*
 * Shared constants and carrier types for the shared port pin control block.
 * Assumes a single core clock with synchronous active-high reset.
 */
package spc_pkg;
	// =====================================================================
	// Port widths
	localparam int PA_W = 8;
	localparam int PC_W = 2;
	localparam int PD_W = 6;
	localparam int PE_W = 5;

	// =====================================================================
	// Register offsets
	localparam logic [4:0] OFF_PA_DATA = 5'h00;
	localparam logic [4:0] OFF_PC_DATA = 5'h01;
	localparam logic [4:0] OFF_PD_DATA = 5'h02;
	localparam logic [4:0] OFF_PE_DATA = 5'h03;
	localparam logic [4:0] OFF_PA_DIR = 5'h04;
	localparam logic [4:0] OFF_PC_DIR = 5'h05;
	localparam logic [4:0] OFF_PD_DIR = 5'h06;
	localparam logic [4:0] OFF_PE_DIR = 5'h07;
	localparam logic [4:0] OFF_PA_PULL = 5'h08;
	localparam logic [4:0] OFF_PC_PULL = 5'h09;
	localparam logic [4:0] OFF_PE_PULL = 5'h0A;
	localparam logic [4:0] OFF_PD_SINK = 5'h0B;
	localparam logic [4:0] OFF_KEY_EN = 5'h0C;
	localparam logic [4:0] OFF_CTRL = 5'h0D;
	localparam logic [4:0] OFF_IRQ_STAT = 5'h0E;
	localparam logic [4:0] OFF_IRQ_MASK = 5'h0F;
	localparam logic [4:0] OFF_PA_PIN = 5'h10;
	localparam logic [4:0] OFF_PC_PIN = 5'h11;
	localparam logic [4:0] OFF_PD_PIN = 5'h12;
	localparam logic [4:0] OFF_PE_PIN = 5'h13;

	// =====================================================================
	// Control register fields
	localparam int CTRL_SERIAL_EN = 0;
	localparam int CTRL_USB_EN = 1;
	localparam int CTRL_USB_PULL = 2;
	localparam int CTRL_PE4_IRQ_EN = 3;
	localparam int CTRL_T_A_OUT = 4;
	localparam int CTRL_T_B_OUT = 5;

	// Interrupt status fields
	localparam int IRQ_KEY = 0;
	localparam int IRQ_PE4 = 1;
	localparam int IRQ_W = 2;

	// =====================================================================
	// Reset values
	localparam logic [7:0] RST_ZERO = 8'h00;

	// Pin triple: input, output value, output enable
	typedef struct packed {
		logic in;
		logic out;
		logic oe;
	} spc_pin_t;

	// Per-pin pad controls besides drive
	typedef struct packed {
		logic pull_up;
		logic high_sink;
	} spc_pad_t;
endpackage : spc_pkg

// File: spc_sync.sv
/*
 * Three-stage input synchroniser for pin inputs.
 * Assumes inputs may change at any time relative to i_core_clk.
 */
`timescale 1ns/1ps
module spc_sync #(
	parameter int W = 8
) (
	input wire logic i_core_clk, // Core clock
	input wire logic i_reset, // Sync reset
	input wire logic [W-1:0] i_async, // Raw pin levels
	output logic [W-1:0] o_sync // Settled levels
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;

	// =====================================================================
	// Chain; output follows once stages two and three agree
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			o_sync <= '0;
		end else begin
			s1_q <= i_async;
			s2_q <= s1_q;
			s3_q <= s2_q;
			for (int i = 0; i < W; i++) begin
				if (s2_q[i] == s3_q[i]) begin
					o_sync[i] <= s3_q[i];
				end
			end
		end
	end
endmodule : spc_sync

// File: spc_pad_drive.sv
/*
 * Drive logic of one port's pins: push-pull or open-drain.
 * Assumes direction and data come from registers on the same clock.
 */
`timescale 1ns/1ps
module spc_pad_drive #(
	parameter int W = 8,
	parameter bit OPEN_DRAIN = 1'b0
) (
	input wire logic [W-1:0] i_dir, // 1 = output
	input wire logic [W-1:0] i_data, // Output value
	output logic [W-1:0] o_out, // Pad output value
	output logic [W-1:0] o_oe // Pad output enable
);
	// =====================================================================
	// Open-drain drives only a low; a high releases the pin
	always_comb begin
		for (int i = 0; i < W; i++) begin
			o_out[i] = OPEN_DRAIN ? 1'b0 : i_data[i];
			o_oe[i] = i_dir[i] & (OPEN_DRAIN ? ~i_data[i] : 1'b1);
		end
	end
endmodule : spc_pad_drive

// File: spc_port_ctrl.sv
/*
 * Shared port pin control: ports A, C, D and E with pull-ups, sink modes,
 * open-drain drive, keyboard and port E bit 4 interrupt, serial, timer and
 * USB pin sharing. Register port: address, write data, strobes, read data
 * one cycle later. Assumes one clock and a synchronous active-high reset.
 */
// How it works
// (R1) Eight-bit port A, per-pin keyboard interrupt
// (R2) Port A/C pull-ups only when input
// (R3) Port C two bits, shared with serial
// (R4) Serial: bit0 transmit out, bit1 receive in
// (R5) Port D six bits, open-drain outputs
// (R6) Port D sink: bits1-0 25mA, upper 10mA
// (R7) Port E five bits: USB and timers
// (R8) Port E bits2-0 pull-up in any direction
// (R9) E0 timer clock, E1 timer A, E2 timer B
// (R10) USB off: E4,E3 general pins, 10mA sink
// (R11) E4,E3 open-drain out, pull-up when input
// (R12) E4 can trigger external interrupt
// (R13) USB on: E4 minus, E3 plus lines
// (R14) USB minus line switchable pull-up
// (R15) USB mode ignores E4,E3 direction/data
`timescale 1ns/1ps
module spc_port_ctrl (
	input wire logic i_core_clk, // Core clock, 50 MHz
	input wire logic i_reset, // Sync reset, active high
	input wire logic [4:0] i_addr, // Register address
	input wire logic [7:0] i_wdata, // Write data
	input wire logic i_wr, // Write strobe
	input wire logic i_rd, // Read strobe
	output logic [7:0] o_rdata, // Read data, cycle after strobe
	output logic o_irq, // Level interrupt
	output logic o_ext_irq, // Port E bit 4 to external interrupt
	output logic [7:0] o_key_pins, // Synced port A levels, masked by the keyboard enables, to keyboard module
	input wire logic [7:0] i_pa_in, // Port A pad inputs
	output logic [7:0] o_pa_out, // Port A pad outputs
	output logic [7:0] o_pa_oe, // Port A pad enables
	output logic [7:0] o_pa_pull, // Port A pull-ups
	input wire logic [1:0] i_pc_in, // Port C pad inputs
	output logic [1:0] o_pc_out, // Port C pad outputs
	output logic [1:0] o_pc_oe, // Port C pad enables
	output logic [1:0] o_pc_pull, // Port C pull-ups
	input wire logic i_serial_tx, // Serial transmit data
	output logic o_serial_rx, // Serial receive data
	input wire logic [5:0] i_pd_in, // Port D pad inputs
	output logic [5:0] o_pd_out, // Port D pad outputs
	output logic [5:0] o_pd_oe, // Port D pad enables
	output logic [5:0] o_pd_sink_high, // Port D high-sink select
	input wire logic [4:0] i_pe_in, // Port E pad inputs
	output logic [4:0] o_pe_out, // Port E pad outputs
	output logic [4:0] o_pe_oe, // Port E pad enables
	output logic [4:0] o_pe_pull, // Port E pull-ups
	output logic o_timer_ext_clk, // Timer external clock
	input wire logic i_timer_a_out, // Timer A channel output
	output logic o_timer_a_in, // Timer A channel input
	input wire logic i_timer_b_out, // Timer B channel output
	output logic o_timer_b_in, // Timer B channel input
	output logic o_usb_en, // USB owns port E bits 4 and 3
	output logic o_usb_minus_pull, // USB minus line pull-up on
	output logic o_usb_plus_in, // USB plus line level
	output logic o_usb_minus_in, // USB minus line level
	input wire logic i_usb_plus_out, // USB plus drive value
	input wire logic i_usb_minus_out, // USB minus drive value
	input wire logic i_usb_drive // USB driving the lines
);
	// =====================================================================
	// Registers
	logic [7:0] pa_data_q, pa_dir_q, pa_pull_q, key_en_q;
	logic [1:0] pc_data_q, pc_dir_q, pc_pull_q;
	logic [5:0] pd_data_q, pd_dir_q, pd_sink_q;
	logic [4:0] pe_data_q, pe_dir_q, pe_pull_q;
	logic [7:0] ctrl_q;
	logic [1:0] stat_q, mask_q;
	logic [7:0] key_prev_q;
	logic pe4_prev_q;
	logic [7:0] pa_s;
	logic [1:0] pc_s;
	logic [5:0] pd_s;
	logic [4:0] pe_s;

	function automatic logic wr_at(input logic [4:0] off);
		wr_at = i_wr && (i_addr == off);
	endfunction : wr_at

	// =====================================================================
	// Input synchronisers
	spc_sync #(.W(spc_pkg::PA_W)) u_sync_a (.i_core_clk(i_core_clk), .i_reset(i_reset), .i_async(i_pa_in),
		.o_sync(pa_s));
	spc_sync #(.W(spc_pkg::PC_W)) u_sync_c (.i_core_clk(i_core_clk), .i_reset(i_reset), .i_async(i_pc_in),
		.o_sync(pc_s));
	spc_sync #(.W(spc_pkg::PD_W)) u_sync_d (.i_core_clk(i_core_clk), .i_reset(i_reset), .i_async(i_pd_in),
		.o_sync(pd_s));
	spc_sync #(.W(spc_pkg::PE_W)) u_sync_e (.i_core_clk(i_core_clk), .i_reset(i_reset), .i_async(i_pe_in),
		.o_sync(pe_s));

	// =====================================================================
	// Software registers
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			pa_data_q <= spc_pkg::RST_ZERO;
			pa_dir_q <= spc_pkg::RST_ZERO;
			pa_pull_q <= spc_pkg::RST_ZERO;
			key_en_q <= spc_pkg::RST_ZERO;
			pc_data_q <= spc_pkg::RST_ZERO[1:0];
			pc_dir_q <= spc_pkg::RST_ZERO[1:0];
			pc_pull_q <= spc_pkg::RST_ZERO[1:0];
			pd_data_q <= spc_pkg::RST_ZERO[5:0];
			pd_dir_q <= spc_pkg::RST_ZERO[5:0];
			pd_sink_q <= spc_pkg::RST_ZERO[5:0];
			pe_data_q <= spc_pkg::RST_ZERO[4:0];
			pe_dir_q <= spc_pkg::RST_ZERO[4:0];
			pe_pull_q <= spc_pkg::RST_ZERO[4:0];
			ctrl_q <= spc_pkg::RST_ZERO;
			mask_q <= spc_pkg::RST_ZERO[1:0];
		end else begin
			if (wr_at(spc_pkg::OFF_PA_DATA)) pa_data_q <= i_wdata;
			if (wr_at(spc_pkg::OFF_PA_DIR)) pa_dir_q <= i_wdata;
			if (wr_at(spc_pkg::OFF_PA_PULL)) pa_pull_q <= i_wdata;
			if (wr_at(spc_pkg::OFF_KEY_EN)) key_en_q <= i_wdata; // [R1]
			if (wr_at(spc_pkg::OFF_PC_DATA)) pc_data_q <= i_wdata[1:0];
			if (wr_at(spc_pkg::OFF_PC_DIR)) pc_dir_q <= i_wdata[1:0];
			if (wr_at(spc_pkg::OFF_PC_PULL)) pc_pull_q <= i_wdata[1:0];
			if (wr_at(spc_pkg::OFF_PD_DATA)) pd_data_q <= i_wdata[5:0];
			if (wr_at(spc_pkg::OFF_PD_DIR)) pd_dir_q <= i_wdata[5:0];
			if (wr_at(spc_pkg::OFF_PD_SINK)) pd_sink_q <= i_wdata[5:0];
			if (wr_at(spc_pkg::OFF_PE_DATA)) pe_data_q <= i_wdata[4:0];
			if (wr_at(spc_pkg::OFF_PE_DIR)) pe_dir_q <= i_wdata[4:0];
			if (wr_at(spc_pkg::OFF_PE_PULL)) pe_pull_q <= i_wdata[4:0];
			if (wr_at(spc_pkg::OFF_CTRL)) ctrl_q <= {2'h0, i_wdata[5:0]};
			if (wr_at(spc_pkg::OFF_IRQ_MASK)) mask_q <= i_wdata[1:0];
		end
	end

	logic usb_on;
	logic ser_on;
	assign usb_on = ctrl_q[spc_pkg::CTRL_USB_EN];
	assign ser_on = ctrl_q[spc_pkg::CTRL_SERIAL_EN];

	// =====================================================================
	// Pad drive, combinational then registered
	logic [7:0] a_out, a_oe;
	logic [1:0] c_out, c_oe;
	logic [5:0] d_out, d_oe;
	logic [4:0] e_out, e_oe;
	logic [2:0] e_lo_out, e_lo_oe;
	logic [1:0] e_hi_out, e_hi_oe;

	spc_pad_drive #(.W(8), .OPEN_DRAIN(1'b0)) u_drv_a (.i_dir(pa_dir_q), .i_data(pa_data_q),
		.o_out(a_out), .o_oe(a_oe));
	spc_pad_drive #(.W(2), .OPEN_DRAIN(1'b0)) u_drv_c (.i_dir(pc_dir_q), .i_data(pc_data_q),
		.o_out(c_out), .o_oe(c_oe));
	spc_pad_drive #(.W(6), .OPEN_DRAIN(1'b1)) u_drv_d (.i_dir(pd_dir_q), .i_data(pd_data_q),
		.o_out(d_out), .o_oe(d_oe)); // [R5]
	spc_pad_drive #(.W(3), .OPEN_DRAIN(1'b0)) u_drv_el (.i_dir(pe_dir_q[2:0]), .i_data(pe_data_q[2:0]),
		.o_out(e_lo_out), .o_oe(e_lo_oe));
	spc_pad_drive #(.W(2), .OPEN_DRAIN(1'b1)) u_drv_eh (.i_dir(pe_dir_q[4:3]), .i_data(pe_data_q[4:3]),
		.o_out(e_hi_out), .o_oe(e_hi_oe)); // [R11]

	logic [1:0] c_out_m, c_oe_m;
	logic [4:0] e_out_m, e_oe_m;
	always_comb begin
		c_out_m = c_out;
		c_oe_m = c_oe;
		if (ser_on) begin
			c_out_m[0] = i_serial_tx; // [R4]
			c_oe_m[0] = 1'b1;
			c_out_m[1] = 1'b0;
			c_oe_m[1] = 1'b0; // [R3]
		end
		e_out_m = {e_hi_out, e_lo_out};
		e_oe_m = {e_hi_oe, e_lo_oe};
		if (ctrl_q[spc_pkg::CTRL_T_A_OUT]) begin
			e_out_m[1] = i_timer_a_out; // [R9]
			e_oe_m[1] = 1'b1;
		end
		if (ctrl_q[spc_pkg::CTRL_T_B_OUT]) begin
			e_out_m[2] = i_timer_b_out; // [R9]
			e_oe_m[2] = 1'b1;
		end
		if (usb_on) begin
			e_out_m[4:3] = {i_usb_minus_out, i_usb_plus_out}; // [R13] [R15]
			e_oe_m[4:3] = {2{i_usb_drive}};
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			o_pa_out <= spc_pkg::RST_ZERO;
			o_pa_oe <= spc_pkg::RST_ZERO;
			o_pc_out <= spc_pkg::RST_ZERO[1:0];
			o_pc_oe <= spc_pkg::RST_ZERO[1:0];
			o_pd_out <= spc_pkg::RST_ZERO[5:0];
			o_pd_oe <= spc_pkg::RST_ZERO[5:0];
			o_pe_out <= spc_pkg::RST_ZERO[4:0];
			o_pe_oe <= spc_pkg::RST_ZERO[4:0];
		end else begin
			o_pa_out <= a_out; // [R1]
			o_pa_oe <= a_oe;
			o_pc_out <= c_out_m;
			o_pc_oe <= c_oe_m;
			o_pd_out <= d_out;
			o_pd_oe <= d_oe;
			o_pe_out <= e_out_m; // [R7]
			o_pe_oe <= e_oe_m;
		end
	end

	// =====================================================================
	// Pad options
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			o_pa_pull <= spc_pkg::RST_ZERO;
			o_pc_pull <= spc_pkg::RST_ZERO[1:0];
			o_pe_pull <= spc_pkg::RST_ZERO[4:0];
			o_pd_sink_high <= spc_pkg::RST_ZERO[5:0];
			o_usb_en <= 1'b0;
			o_usb_minus_pull <= 1'b0;
		end else begin
			o_pa_pull <= pa_pull_q & ~pa_dir_q; // [R2]
			o_pc_pull <= pc_pull_q & ~(ser_on ? 2'h1 : pc_dir_q); // [R2]
			o_pe_pull[2:0] <= pe_pull_q[2:0]; // [R8]
			o_pe_pull[4:3] <= usb_on ? 2'h0 : (pe_pull_q[4:3] & ~pe_dir_q[4:3]); // [R11]
			// Bits 1-0 select the 25mA mode, bits 5-2 the 10mA mode
			o_pd_sink_high <= pd_sink_q; // [R6]
			o_usb_en <= usb_on; // [R10] [R13]
			o_usb_minus_pull <= usb_on & ctrl_q[spc_pkg::CTRL_USB_PULL]; // [R14]
		end
	end

	// =====================================================================
	// Inputs to peripherals
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			o_key_pins <= spc_pkg::RST_ZERO;
			o_serial_rx <= 1'b1;
			o_timer_ext_clk <= 1'b0;
			o_timer_a_in <= 1'b0;
			o_timer_b_in <= 1'b0;
			o_usb_plus_in <= 1'b0;
			o_usb_minus_in <= 1'b0;
		end else begin
			o_key_pins <= pa_s & key_en_q; // [R1]
			o_serial_rx <= ser_on ? pc_s[1] : 1'b1; // [R4]
			o_timer_ext_clk <= pe_s[0]; // [R9]
			o_timer_a_in <= pe_s[1];
			o_timer_b_in <= pe_s[2];
			o_usb_plus_in <= usb_on & pe_s[3]; // [R13]
			o_usb_minus_in <= usb_on & pe_s[4];
		end
	end

	// =====================================================================
	// Events: keyboard falling edge, port E bit 4 falling edge
	logic key_evt;
	logic pe4_evt;
	assign key_evt = |(key_prev_q & ~pa_s & key_en_q); // [R1]
	assign pe4_evt = ctrl_q[spc_pkg::CTRL_PE4_IRQ_EN] & ~usb_on & pe4_prev_q & ~pe_s[4]; // [R12]

	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			key_prev_q <= spc_pkg::RST_ZERO;
			pe4_prev_q <= 1'b0;
			stat_q <= 2'h0;
			o_ext_irq <= 1'b0;
		end else begin
			key_prev_q <= pa_s;
			pe4_prev_q <= pe_s[4];
			for (int i = 0; i < spc_pkg::IRQ_W; i++) begin
				if (wr_at(spc_pkg::OFF_IRQ_STAT) && i_wdata[i]) stat_q[i] <= 1'b0;
			end
			// Set wins over a same-cycle clear
			if (key_evt) stat_q[spc_pkg::IRQ_KEY] <= 1'b1;
			if (pe4_evt) stat_q[spc_pkg::IRQ_PE4] <= 1'b1;
			o_ext_irq <= pe4_evt; // [R12]
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			o_irq <= 1'b0;
		end else begin
			o_irq <= |(stat_q & mask_q);
		end
	end

	// =====================================================================
	// Read port
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			o_rdata <= spc_pkg::RST_ZERO;
		end else if (i_rd) begin
			unique case (i_addr)
				spc_pkg::OFF_PA_DATA: o_rdata <= pa_data_q;
				spc_pkg::OFF_PC_DATA: o_rdata <= {6'h00, pc_data_q};
				spc_pkg::OFF_PD_DATA: o_rdata <= {2'h0, pd_data_q};
				spc_pkg::OFF_PE_DATA: o_rdata <= {3'h0, pe_data_q};
				spc_pkg::OFF_PA_DIR: o_rdata <= pa_dir_q;
				spc_pkg::OFF_PC_DIR: o_rdata <= {6'h00, pc_dir_q};
				spc_pkg::OFF_PD_DIR: o_rdata <= {2'h0, pd_dir_q};
				spc_pkg::OFF_PE_DIR: o_rdata <= {3'h0, pe_dir_q};
				spc_pkg::OFF_PA_PULL: o_rdata <= pa_pull_q;
				spc_pkg::OFF_PC_PULL: o_rdata <= {6'h00, pc_pull_q};
				spc_pkg::OFF_PE_PULL: o_rdata <= {3'h0, pe_pull_q};
				spc_pkg::OFF_PD_SINK: o_rdata <= {2'h0, pd_sink_q};
				spc_pkg::OFF_KEY_EN: o_rdata <= key_en_q;
				spc_pkg::OFF_CTRL: o_rdata <= ctrl_q;
				spc_pkg::OFF_IRQ_STAT: o_rdata <= {6'h00, stat_q};
				spc_pkg::OFF_IRQ_MASK: o_rdata <= {6'h00, mask_q};
				spc_pkg::OFF_PA_PIN: o_rdata <= pa_s;
				spc_pkg::OFF_PC_PIN: o_rdata <= {6'h00, pc_s};
				spc_pkg::OFF_PD_PIN: o_rdata <= {2'h0, pd_s};
				spc_pkg::OFF_PE_PIN: o_rdata <= {3'h0, pe_s};
				default: o_rdata <= 8'h00;
			endcase
		end else begin
			o_rdata <= 8'h00;
		end
	end
endmodule : spc_port_ctrl

// File: spc_pad_world.sv
/*
 * Board side of one port: pads, external drivers and pull-ups.
 * Assumes the bench sets the external drive after a rising clock edge.
 */
`timescale 1ns/1ps
module spc_pad_world #(
	parameter int W = 8
) (
	input wire logic i_core_clk, // Core clock
	input wire logic [W-1:0] i_out, // Pad output value
	input wire logic [W-1:0] i_oe, // Pad output enable
	input wire logic [W-1:0] i_pull, // Pull-up on
	input wire logic [W-1:0] i_ext_en, // Board drives the pin
	input wire logic [W-1:0] i_ext_val, // Board drive value
	output logic [W-1:0] o_level // Resolved pin level
);
	// =====================================================================
	// Floating pins
	logic [W-1:0] float_q = '0;
	// A floating pin without pull-up changes every cycle, never holds
	always_ff @(posedge i_core_clk) begin
		float_q <= ~float_q;
	end
	// =====================================================================
	// Wired resolution: low wins between drivers
	always_comb begin
		for (int k = 0; k < W; k++) begin
			if (i_oe[k] || i_ext_en[k]) begin
				o_level[k] = (i_oe[k] ? i_out[k] : 1'b1) & (i_ext_en[k] ? i_ext_val[k] : 1'b1);
			end else begin
				o_level[k] = i_pull[k] ? 1'b1 : float_q[k];
			end
		end
	end
endmodule : spc_pad_world

// File: spc_port_ctrl_sva.sv
/*
 * Checker for the shared port pin control block.
 * Assumes it is bound to the block's top module and sees only its ports.
 */
`timescale 1ns/1ps
module spc_port_ctrl_sva (
	input wire logic i_core_clk, // Core clock
	input wire logic i_reset, // Sync reset
	input wire logic i_usb_drive, // USB driving
	input wire logic o_ext_irq, // External interrupt pulse
	input wire logic o_irq, // Level interrupt
	input wire logic [7:0] o_pa_oe, // Port A enables
	input wire logic [7:0] o_pa_pull, // Port A pull-ups
	input wire logic [1:0] o_pc_oe, // Port C enables
	input wire logic [1:0] o_pc_pull, // Port C pull-ups
	input wire logic [5:0] o_pd_out, // Port D outputs
	input wire logic [4:0] o_pe_out, // Port E outputs
	input wire logic [4:0] o_pe_oe, // Port E enables
	input wire logic [4:0] o_pe_pull, // Port E pull-ups
	input wire logic o_usb_en, // USB owns pins
	input wire logic o_usb_minus_pull, // Minus line pull-up
	input wire logic o_usb_plus_in, // Plus line level
	input wire logic o_usb_minus_in // Minus line level
);
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (i_reset);
	// =====================================================================
	// Assertions
	a_pd_open_drain: assert property (o_pd_out == 6'h00)
		else $error("port D drives high");
	a_pa_pull_input: assert property ((o_pa_pull & o_pa_oe) == 8'h00)
		else $error("port A pull-up on output pin");
	a_pc_pull_input: assert property ((o_pc_pull & o_pc_oe) == 2'h0)
		else $error("port C pull-up on output pin");
	a_pe_hi_od: assert property (!o_usb_en [*3] |-> (o_pe_out[4:3] & o_pe_oe[4:3]) == 2'h0)
		else $error("port E upper pins drive high");
	a_pe_hi_pull: assert property (!o_usb_en [*3] |-> (o_pe_pull[4:3] & o_pe_oe[4:3]) == 2'h0)
		else $error("port E upper pull-up on output pin");
	a_usb_no_gp_pull: assert property (o_usb_en [*3] |-> o_pe_pull[4:3] == 2'h0)
		else $error("general pull-up while USB owns pins");
	a_usb_in_gated: assert property (!o_usb_en [*3] |-> !o_usb_plus_in && !o_usb_minus_in)
		else $error("USB line levels pass while USB off");
	a_usb_idle_oe: assert property ((o_usb_en && !i_usb_drive) [*3] |-> o_pe_oe[4:3] == 2'h0)
		else $error("general settings drive USB lines");
	a_usb_drive_oe: assert property ((o_usb_en && i_usb_drive) [*3] |-> o_pe_oe[4:3] == 2'h3)
		else $error("USB drive not on pins");
	a_ext_irq_pulse: assert property (o_ext_irq |=> !o_ext_irq)
		else $error("external interrupt pulse too long");
	// =====================================================================
	// Coverage
	c_ext_irq: cover property (o_ext_irq);
	c_irq: cover property (o_irq);
	c_usb_pull: cover property (o_usb_en && o_usb_minus_pull);
endmodule : spc_port_ctrl_sva

bind spc_port_ctrl spc_port_ctrl_sva chk_u (.i_core_clk, .i_reset, .i_usb_drive, .o_ext_irq, .o_irq,
	.o_pa_oe, .o_pa_pull, .o_pc_oe, .o_pc_pull, .o_pd_out, .o_pe_out, .o_pe_oe, .o_pe_pull,
	.o_usb_en, .o_usb_minus_pull, .o_usb_plus_in, .o_usb_minus_in);

// File: shared_port_pin_control_bench.sv
/*
 * Self-checking bench for the shared port pin control block.
 * Assumes the register map of spc_pkg and one 50 MHz clock.
 */
`timescale 1ns/1ps
module shared_port_pin_control_bench;
	logic i_core_clk, i_reset, i_wr, i_rd, i_serial_tx, i_timer_a_out, i_timer_b_out;
	logic i_usb_plus_out, i_usb_minus_out, i_usb_drive, o_irq, o_ext_irq, o_serial_rx;
	logic o_timer_ext_clk, o_timer_a_in, o_timer_b_in, o_usb_en, o_usb_minus_pull, o_usb_plus_in, o_usb_minus_in;
	logic [4:0] i_addr, i_pe_in, o_pe_out, o_pe_oe, o_pe_pull, e_en, e_val;
	logic [7:0] i_wdata, o_rdata, o_key_pins, i_pa_in, o_pa_out, o_pa_oe, o_pa_pull, a_en, a_val, d, r, p, v;
	logic [1:0] i_pc_in, o_pc_out, o_pc_oe, o_pc_pull, c_en, c_val;
	logic [5:0] i_pd_in, o_pd_out, o_pd_oe, o_pd_sink_high;
	int bad_count, checks;

	spc_port_ctrl dut_u (.i_core_clk, .i_reset, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_irq, .o_ext_irq,
		.o_key_pins, .i_pa_in, .o_pa_out, .o_pa_oe, .o_pa_pull, .i_pc_in, .o_pc_out, .o_pc_oe, .o_pc_pull,
		.i_serial_tx, .o_serial_rx, .i_pd_in, .o_pd_out, .o_pd_oe, .o_pd_sink_high, .i_pe_in, .o_pe_out,
		.o_pe_oe, .o_pe_pull, .o_timer_ext_clk, .i_timer_a_out, .o_timer_a_in, .i_timer_b_out, .o_timer_b_in,
		.o_usb_en, .o_usb_minus_pull, .o_usb_plus_in, .o_usb_minus_in, .i_usb_plus_out, .i_usb_minus_out,
		.i_usb_drive);
	spc_pad_world #(.W(8)) pa_u (.i_core_clk, .i_out(o_pa_out), .i_oe(o_pa_oe), .i_pull(o_pa_pull),
		.i_ext_en(a_en), .i_ext_val(a_val), .o_level(i_pa_in));
	spc_pad_world #(.W(2)) pc_u (.i_core_clk, .i_out(o_pc_out), .i_oe(o_pc_oe), .i_pull(o_pc_pull),
		.i_ext_en(c_en), .i_ext_val(c_val), .o_level(i_pc_in));
	spc_pad_world #(.W(6)) pd_u (.i_core_clk, .i_out(o_pd_out), .i_oe(o_pd_oe), .i_pull(6'h00),
		.i_ext_en(6'(a_en)), .i_ext_val(6'(a_val)), .o_level(i_pd_in));
	spc_pad_world #(.W(5)) pe_u (.i_core_clk, .i_out(o_pe_out), .i_oe(o_pe_oe),
		.i_pull(o_pe_pull | {o_usb_minus_pull, 4'h0}), .i_ext_en(e_en), .i_ext_val(e_val), .o_level(i_pe_in));

	// =====================================================================
	// Expectations and bus tasks
	function automatic logic [7:0] od_oe(logic [7:0] dir, logic [7:0] dat);
		return dir & ~dat;
	endfunction : od_oe
	function automatic logic [7:0] pull_in(logic [7:0] pul, logic [7:0] dir);
		return pul & ~dir;
	endfunction : pull_in
	task automatic complete_run();
		$display("Totals: %0d checks, %0d bad", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : complete_run
	task automatic check(string nm, logic [7:0] seen, logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task automatic wr(logic [4:0] a, logic [7:0] x);
		@(posedge i_core_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= x;
		@(posedge i_core_clk);
		i_wr <= 1'b0;
	endtask : wr
	task automatic rd_chk(string nm, logic [4:0] a, logic [7:0] exp);
		@(posedge i_core_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_core_clk);
		i_rd <= 1'b0;
		@(negedge i_core_clk);
		check(nm, o_rdata, exp);
	endtask : rd_chk
	task automatic settle(int n);
		repeat (n) @(posedge i_core_clk);
		@(negedge i_core_clk);
	endtask : settle
	task automatic wait_ext();
		for (int k = 0; k < 20; k++) begin
			@(negedge i_core_clk);
			if (o_ext_irq === 1'b1) break;
		end
		check("ext_irq", 8'(o_ext_irq), 8'h01);
		if (o_ext_irq !== 1'b1) complete_run();
	endtask : wait_ext

	initial begin
		i_core_clk = 1'b0;
		forever #10 i_core_clk = ~i_core_clk;
	end

	// =====================================================================
	// Main sequence
	initial begin
		{i_reset, i_wr, i_rd, i_serial_tx, i_timer_a_out, i_timer_b_out} = 6'h20;
		{i_usb_plus_out, i_usb_minus_out, i_usb_drive, i_addr, i_wdata} = 16'h0000;
		{a_en, a_val, c_en, c_val, e_en, e_val} = 30'h0;
		{bad_count, checks} = 0;
		v = 8'($urandom(32'h5DF8));
		repeat (4) @(posedge i_core_clk);
		i_reset <= 1'b0;
		settle(0);
		check("serial_rx", 8'(o_serial_rx), 8'h01);
		for (int k = 0; k < 16; k++) rd_chk("reset_reg", 5'(k), 8'h00);
		rd_chk("unmapped", 5'h1F, 8'h00);
		$display("test reset done");
		for (int k = 0; k < 4; k++) begin
			d = (k == 0) ? 8'h00 : 8'($urandom);
			r = 8'($urandom);
			p = (k == 0) ? 8'hFF : 8'($urandom);
			wr(spc_pkg::OFF_PA_DIR, d);
			wr(spc_pkg::OFF_PA_DATA, r);
			wr(spc_pkg::OFF_PA_PULL, p);
			settle(2);
			check("pa_oe", o_pa_oe, d);
			check("pa_out", o_pa_out & d, r & d);
			check("pa_pull", o_pa_pull, pull_in(p, d));
		end
		wr(spc_pkg::OFF_PA_DIR, 8'h00);
		a_en <= 8'hFF;
		a_val <= v;
		settle(6);
		rd_chk("pa_pin", spc_pkg::OFF_PA_PIN, v);
		$display("test port A done");
		wr(spc_pkg::OFF_PC_DATA, 8'hFF);
		rd_chk("pc_width", spc_pkg::OFF_PC_DATA, 8'h03);
		wr(spc_pkg::OFF_PC_PULL, 8'h03);
		wr(spc_pkg::OFF_PC_DIR, 8'h01);
		settle(2);
		check("pc_pull", 8'(o_pc_pull), 8'h02);
		wr(spc_pkg::OFF_CTRL, 8'h01);
		c_en <= 2'h2;
		c_val <= v[1:0];
		i_serial_tx <= ~v[0];
		settle(6);
		check("pc_oe", 8'(o_pc_oe), 8'h01);
		check("pc_tx", 8'(o_pc_out[0]), 8'(!v[0]));
		check("serial_rx", 8'(o_serial_rx), 8'(v[1]));
		$display("test port C done");
		for (int k = 0; k < 4; k++) begin
			d = 8'($urandom);
			r = 8'($urandom);
			p = 8'($urandom);
			wr(spc_pkg::OFF_PD_DIR, d);
			wr(spc_pkg::OFF_PD_DATA, r);
			wr(spc_pkg::OFF_PD_SINK, p);
			settle(2);
			check("pd_oe", 8'(o_pd_oe), od_oe(d, r) & 8'h3F);
			check("pd_sink", 8'(o_pd_sink_high), p & 8'h3F);
			rd_chk("pd_width", spc_pkg::OFF_PD_DATA, r & 8'h3F);
			rd_chk("pd_pin", spc_pkg::OFF_PD_PIN, v & ~od_oe(d, r) & 8'h3F);
		end
		$display("test port D done");
		wr(spc_pkg::OFF_CTRL, 8'h00);
		for (int k = 0; k < 4; k++) begin
			d = (k == 0) ? 8'hFF : 8'($urandom);
			r = (k == 0) ? 8'h00 : 8'($urandom);
			p = (k == 0) ? 8'hFF : 8'($urandom);
			wr(spc_pkg::OFF_PE_DIR, d);
			wr(spc_pkg::OFF_PE_DATA, r);
			wr(spc_pkg::OFF_PE_PULL, p);
			settle(2);
			check("pe_oe", 8'(o_pe_oe), (d & 8'h07) | (od_oe(d, r) & 8'h18));
			check("pe_pull", 8'(o_pe_pull), (p & 8'h07) | (pull_in(p, d) & 8'h18));
			check("pe_od", 8'(o_pe_out & 5'h18), 8'h00);
		end
		rd_chk("pe_width", spc_pkg::OFF_PE_DATA, r & 8'h1F);
		wr(spc_pkg::OFF_PE_DIR, 8'h00);
		e_en <= 5'h1F;
		e_val <= v[4:0];
		settle(6);
		check("timer_in", 8'({o_timer_b_in, o_timer_a_in, o_timer_ext_clk}), v & 8'h07);
		wr(spc_pkg::OFF_CTRL, 8'h30);
		wr(spc_pkg::OFF_PE_DIR, 8'h06);
		e_en <= 5'h00;
		i_timer_a_out <= v[5];
		i_timer_b_out <= v[6];
		settle(3);
		check("timer_out", 8'(o_pe_out[2:1]), 8'(v[6:5]));
		$display("test port E done");
		wr(spc_pkg::OFF_PE_DIR, 8'h1F);
		wr(spc_pkg::OFF_PE_DATA, 8'h1F);
		wr(spc_pkg::OFF_CTRL, 8'h06);
		i_usb_drive <= 1'b1;
		i_usb_plus_out <= v[2];
		i_usb_minus_out <= ~v[2];
		settle(3);
		check("usb_oe", 8'(o_pe_oe & 5'h18), 8'h18);
		check("usb_out", 8'(o_pe_out & 5'h18), {3'h0, ~v[2], v[2], 3'h0});
		check("usb_pull", 8'({o_usb_en, o_usb_minus_pull}), 8'h03);
		wr(spc_pkg::OFF_PE_DATA, 8'h00);
		i_usb_drive <= 1'b0;
		e_en <= 5'h18;
		e_val <= ~v[4:0];
		settle(6);
		check("usb_idle_oe", 8'(o_pe_oe & 5'h18), 8'h00);
		check("usb_in", 8'({o_usb_minus_in, o_usb_plus_in}), 8'(v[4:3] ^ 2'h3));
		$display("test USB done");
		wr(spc_pkg::OFF_CTRL, 8'h00);
		wr(spc_pkg::OFF_PE_DIR, 8'h00);
		a_val <= 8'hFF;
		e_en <= 5'h1F;
		e_val <= 5'h1F;
		settle(6);
		wr(spc_pkg::OFF_KEY_EN, 8'h01);
		wr(spc_pkg::OFF_IRQ_MASK, 8'h03);
		wr(spc_pkg::OFF_IRQ_STAT, 8'h03);
		settle(2);
		check("key_pins", o_key_pins, 8'h01);
		check("irq_idle", 8'(o_irq), 8'h00);
		a_val <= 8'hFE;
		settle(6);
		rd_chk("key_stat", spc_pkg::OFF_IRQ_STAT, 8'h01);
		check("irq_set", 8'(o_irq), 8'h01);
		wr(spc_pkg::OFF_IRQ_MASK, 8'h00);
		settle(2);
		check("irq_masked", 8'(o_irq), 8'h00);
		wr(spc_pkg::OFF_IRQ_STAT, 8'h01);
		rd_chk("key_clear", spc_pkg::OFF_IRQ_STAT, 8'h00);
		wr(spc_pkg::OFF_CTRL, 8'h08);
		e_val <= 5'h0F;
		wait_ext();
		rd_chk("pe4_stat", spc_pkg::OFF_IRQ_STAT, 8'h02);
		wr(spc_pkg::OFF_CTRL, 8'h0A);
		e_val <= 5'h1F;
		settle(6);
		wr(spc_pkg::OFF_IRQ_STAT, 8'h03);
		e_val <= 5'h0F;
		settle(8);
		rd_chk("pe4_usb_stat", spc_pkg::OFF_IRQ_STAT, 8'h00);
		$display("test interrupts done");
		complete_run();
	end
endmodule : shared_port_pin_control_bench
